// >>> logic/ddr_cal_params.svh
// Purpose: Constants for the read-window calibration and ECC block.
// Assumes: Word offsets (adr_i[5:2]) on a 32-bit classic Wishbone slave port.
// Notes:   Included by the design module and the bench.
`ifndef DDR_CAL_PARAMS_SVH
`define DDR_CAL_PARAMS_SVH
`define OFS_CONFIG     4'h0
`define OFS_DELAY      4'h1
`define OFS_STATUS     4'h2
`define OFS_IRQ_STAT   4'h3
`define OFS_IRQ_MASK   4'h4
`define CFG_WIDTH_BIT  0
`define CFG_BURST_LSB  1
`define CFG_ECC_BIT    4
`define CFG_UE_FWD_BIT 5
`define CFG_CE_FWD_BIT 6
`define CFG_UPPER_BIT  7
`define DLY_LANE1_LSB  8
`define CFG_RESET      8'h00
`define DLY_RESET      16'h0000
`define EVT_CE_BIT     0
`define EVT_UE_BIT     1
`define EVT_MAX_BIT    2
`define EVT_MAP_BIT    3
`define DDR_BASE       32'h20000000
`define LOW_WINDOW     32'h20000000
`define FULL_WINDOW    32'h40000000
`endif

// >>> logic/ddr_cal_pkg.sv
// Purpose: Shared types for the read-window calibration and ECC block.
// Assumes: Byte-wide system bus requests, two 8-bit memory lanes.
// Notes:   Constants live in ddr_cal_params.svh.
package ddr_cal_pkg;
    typedef struct packed {
        logic        we;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } sb_req_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [29:0] row;
        logic [1:0]  be;
        logic [15:0] wdata;
    } mem_req_t;

    typedef enum {
        S_IDLE,
        S_READ,
        S_DONE
    } sb_state_t;
endpackage

// >>> logic/ddr_read_window_cal_and_ecc.sv
// Purpose: Strobe-delay capture, SEC-DED byte ECC, address map and register file.
// Assumes: Memory lane data arrives on mem_rdata_i each cycle after a read strobe.
// Notes:   The calibration loop itself is run by software over Wishbone.
`timescale 1ns/1ns
`include "ddr_cal_params.svh"
module ddr_read_window_cal_and_ecc #(
    parameter int DLY_W      = 4,           // Width of each lane delay field
    parameter int PHYS_BYTES = 32'h40000000 // Physical memory size in bytes
) (
    input  wire logic               clk_i,        // 125 MHz clock
    input  wire logic               rst_i,        // Synchronous reset, high
    input  wire logic [5:2]         adr_i,        // Wishbone word address
    input  wire logic [31:0]        dat_i,        // Wishbone write data
    output logic [31:0]             dat_o,        // Wishbone read data
    input  wire logic [3:0]         sel_i,        // Wishbone byte selects
    input  wire logic               we_i,         // Wishbone write
    input  wire logic               cyc_i,        // Wishbone cycle
    input  wire logic               stb_i,        // Wishbone strobe
    output logic                    ack_o,        // Wishbone acknowledge
    input  wire logic               init_done_i,  // Controller init complete
    input  wire logic               sb_req_i,     // System bus request pulse
    input  wire ddr_cal_pkg::sb_req_t sb_i,       // System bus request fields
    output logic                    sb_ack_o,     // System bus done pulse
    output logic                    sb_err_o,     // System bus error pulse
    output logic [7:0]              sb_rdata_o,   // System bus read byte
    output ddr_cal_pkg::mem_req_t   mem_o,        // Memory request, one cycle
    input  wire logic [15:0]        mem_rdata_i,  // Raw lane data from memory
    output logic [1:0]              burst_size_o, // Burst size to controller
    output logic                    irq_o         // Level interrupt
);
    import ddr_cal_pkg::*;

    localparam int DEPTH = 1 << DLY_W;
    localparam logic [DLY_W-1:0] DLY_MAX = '1;

    logic [7:0]       cfg_reg;
    logic [DLY_W-1:0] dly_reg [2];
    logic [3:0]       irq_stat_reg;
    logic [3:0]       irq_mask_reg;
    logic [3:0]       evt;
    logic [7:0]       hist_reg [2][DEPTH];
    sb_state_t        state_reg;
    logic [DLY_W:0]   wait_reg;
    logic             lane_reg;
    logic             ecc_op_reg;
    logic             wb_hit;
    logic [31:0]      offs;
    logic [31:0]      window;
    logic             in_map;
    logic [7:0]       cap [2];
    logic [7:0]       fixed;
    logic             ce;
    logic             ue;
    logic             dly_at_max;

    wire width2 = cfg_reg[`CFG_WIDTH_BIT];
    wire ecc_on = cfg_reg[`CFG_ECC_BIT] & width2;

    // A delay at its field limit means calibration ran away; flag it for software
    assign dly_at_max = (dly_reg[0] == DLY_MAX) | (dly_reg[1] == DLY_MAX);

    // SEC-DED check byte: 4 Hamming bits plus overall parity in bit 4
    function automatic logic [7:0] ecc_code(input logic [7:0] d);
        logic [3:0] h;
        h[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
        h[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
        h[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
        h[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
        return {3'h0, ^{d, h}, h};
    endfunction

    // Codeword position (1..12) of each data bit
    function automatic logic [3:0] data_pos(input int i);
        case (i)
            0:       return 4'h3;
            1:       return 4'h5;
            2:       return 4'h6;
            3:       return 4'h7;
            4:       return 4'h9;
            5:       return 4'hA;
            6:       return 4'hB;
            default: return 4'hC;
        endcase
    endfunction

    // Wishbone slave, one wait state: ack follows the request by one edge
    assign wb_hit = cyc_i & stb_i & ~ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= wb_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg <= `CFG_RESET;
        end else if (wb_hit && we_i && adr_i == `OFS_CONFIG && sel_i[0]) begin
            cfg_reg <= dat_i[7:0];
        end
    end

    // Delay fields hold any value; software must stop at the field limit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_reg[0] <= DLY_W'(`DLY_RESET);
            dly_reg[1] <= DLY_W'(`DLY_RESET);
        end else if (wb_hit && we_i && adr_i == `OFS_DELAY) begin
            if (sel_i[0]) begin
                dly_reg[0] <= dat_i[DLY_W-1:0];
            end
            if (sel_i[1]) begin
                dly_reg[1] <= dat_i[`DLY_LANE1_LSB +: DLY_W];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_reg <= 4'h0;
        end else if (wb_hit && we_i && adr_i == `OFS_IRQ_MASK && sel_i[0]) begin
            irq_mask_reg <= dat_i[3:0];
        end
    end

    // Sticky events: a new event in the clearing cycle survives the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= 4'h0;
        end else if (wb_hit && we_i && adr_i == `OFS_IRQ_STAT && sel_i[0]) begin
            irq_stat_reg <= (irq_stat_reg & ~dat_i[3:0]) | evt;
        end else begin
            irq_stat_reg <= irq_stat_reg | evt;
        end
    end

    // Level output: stays high until software clears or masks the status bit
    assign irq_o        = |(irq_stat_reg & irq_mask_reg);
    assign burst_size_o = cfg_reg[`CFG_BURST_LSB +: 2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (wb_hit && !we_i) begin
            dat_o <= 32'h00000000;
            if (adr_i == `OFS_CONFIG) begin
                dat_o[7:0] <= cfg_reg;
            end else if (adr_i == `OFS_DELAY) begin
                dat_o[DLY_W-1:0]                  <= dly_reg[0];
                dat_o[`DLY_LANE1_LSB +: DLY_W]    <= dly_reg[1];
            end else if (adr_i == `OFS_STATUS) begin
                dat_o[0] <= init_done_i;
                dat_o[1] <= ecc_on;
                dat_o[2] <= dly_at_max;
            end else if (adr_i == `OFS_IRQ_STAT) begin
                dat_o[3:0] <= irq_stat_reg;
            end else if (adr_i == `OFS_IRQ_MASK) begin
                dat_o[3:0] <= irq_mask_reg;
            end
        end
    end

    // Capture history per lane; the delay picks how late the byte is taken
    generate
        for (genvar l = 0; l < 2; l++) begin : g_lane
            always_ff @(posedge clk_i) begin
                hist_reg[l][0] <= mem_rdata_i[8*l +: 8];
                for (int k = 1; k < DEPTH; k++) begin
                    hist_reg[l][k] <= hist_reg[l][k-1];
                end
            end
            // Larger delay samples data that arrived later after the strobe
            assign cap[l] = hist_reg[l][DEPTH-1-dly_reg[l]];
        end
    endgenerate

    // Address map: 512 MB window unless upper map selected; ECC caps it at PHYS_BYTES / 2
    always_comb begin
        offs   = sb_i.addr - `DDR_BASE;
        window = cfg_reg[`CFG_UPPER_BIT] ? `FULL_WINDOW : `LOW_WINDOW;
        if (ecc_on) begin
            window = (32'(PHYS_BYTES / 2) < window) ? 32'(PHYS_BYTES / 2) : window;
        end else if (PHYS_BYTES < window) begin
            window = 32'(PHYS_BYTES);
        end
        in_map = (sb_i.addr >= `DDR_BASE) && (offs < window);
    end

    // Single-error correction and double-error detection on the read byte
    always_comb begin
        logic [3:0] syn;
        logic       par;
        logic [7:0] chk;
        syn   = 4'h0;
        par   = 1'b0;
        chk   = ecc_code(cap[0]);
        syn   = chk[3:0] ^ cap[1][3:0];
        par   = ^{cap[0], cap[1][4:0]};
        fixed = cap[0];
        ce    = 1'b0;
        ue    = 1'b0;
        if (ecc_op_reg && (syn != 4'h0 || par)) begin
            if (par) begin
                ce = 1'b1;
                for (int i = 0; i < 8; i++) begin
                    if (syn == data_pos(i)) begin
                        fixed[i] = ~cap[0][i];
                    end
                end
            end else begin
                ue = 1'b1;
            end
        end
    end

    // System bus engine: writes finish next cycle, reads wait for capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg  <= S_IDLE;
            wait_reg   <= '0;
            lane_reg   <= 1'b0;
            ecc_op_reg <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (sb_req_i && in_map && !sb_i.we) begin
                        state_reg  <= S_READ;
                        wait_reg   <= '0;
                        lane_reg   <= width2 & ~ecc_on & offs[0];
                        ecc_op_reg <= ecc_on;
                    end else if (sb_req_i) begin
                        state_reg <= S_DONE;
                    end
                end
                S_READ: begin
                    wait_reg <= wait_reg + 1'b1;
                    if (wait_reg == (DLY_W+1)'(DEPTH)) begin
                        state_reg <= S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    wire rd_done = (state_reg == S_READ) && (wait_reg == (DLY_W+1)'(DEPTH));
    wire map_err = (state_reg == S_IDLE) && sb_req_i && !in_map;
    // Requests arriving while a read is in flight are dropped; the bus side
    // must wait for the done pulse before it asks again

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_o <= '0;
        end else begin
            mem_o <= '0;
            if (state_reg == S_IDLE && sb_req_i && in_map) begin
                mem_o.wr  <= sb_i.we;
                mem_o.rd  <= ~sb_i.we;
                if (ecc_on) begin
                    mem_o.row   <= offs[29:0];
                    mem_o.be    <= 2'b11;
                    mem_o.wdata <= {ecc_code(sb_i.wdata), sb_i.wdata};
                end else if (width2) begin
                    mem_o.row   <= {1'b0, offs[29:1]};
                    mem_o.be    <= offs[0] ? 2'b10 : 2'b01;
                    mem_o.wdata <= {sb_i.wdata, sb_i.wdata};
                end else begin
                    mem_o.row   <= offs[29:0];
                    mem_o.be    <= 2'b01;
                    mem_o.wdata <= {8'h00, sb_i.wdata};
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sb_ack_o   <= 1'b0;
            sb_err_o   <= 1'b0;
            sb_rdata_o <= 8'h00;
        end else begin
            // In-map reads answer only once the capture window has passed
            sb_ack_o <= rd_done | (state_reg == S_IDLE && sb_req_i && (sb_i.we || !in_map));
            sb_err_o <= map_err
                      | (rd_done & ue & cfg_reg[`CFG_UE_FWD_BIT])
                      | (rd_done & ce & cfg_reg[`CFG_CE_FWD_BIT]);
            if (rd_done) begin
                sb_rdata_o <= lane_reg ? cap[1] : fixed;
            end
        end
    end

    always_comb begin
        evt                = 4'h0;
        evt[`EVT_CE_BIT]   = rd_done & ce;
        evt[`EVT_UE_BIT]   = rd_done & ue;
        evt[`EVT_MAX_BIT]  = dly_at_max;
        evt[`EVT_MAP_BIT]  = map_err;
    end
endmodule // ddr_read_window_cal_and_ecc

// >>> verif/ddr_cal_properties.sv
// Purpose: Port assertions for the read calibration and ECC block.
// Assumes: Bench keeps one system bus request in flight.
// Notes:   Read answer latency follows DLY_W.
`timescale 1ns/1ns
module ddr_cal_properties #(
    parameter int DLY_W = 4 // Lane delay field width
) (
    input wire logic                  clk_i,        // Clock
    input wire logic                  rst_i,        // Reset
    input wire logic                  cyc_i,        // Cycle
    input wire logic                  stb_i,        // Strobe
    input wire logic                  we_i,         // Write
    input wire logic                  ack_o,        // Acknowledge
    input wire logic                  sb_req_i,     // Bus request
    input wire ddr_cal_pkg::sb_req_t  sb_i,         // Bus fields
    input wire logic                  sb_ack_o,     // Bus done
    input wire logic                  sb_err_o,     // Bus error
    input wire ddr_cal_pkg::mem_req_t mem_o,        // Memory request
    input wire logic [1:0]            burst_size_o  // Burst size
);
    import ddr_cal_pkg::*;
    localparam int RD_GAP = (1 << DLY_W) + 1 - 8;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_WB_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
    AST_WB_PULSE: assert property (ack_o |=> !ack_o) else $error("ack held");
    AST_WR_CAUSE: assert property (mem_o.wr |-> $past(sb_req_i) && $past(sb_i.we))
        else $error("stray memory write");
    AST_RD_LAT: assert property (mem_o.rd |=> !sb_ack_o [*8] ##RD_GAP sb_ack_o)
        else $error("read answer mistimed");
    AST_MAP_LOW: assert property (sb_req_i && sb_i.addr < 32'h20000000 |=>
        sb_ack_o && sb_err_o && !mem_o.wr && !mem_o.rd) else $error("low address not refused");
    AST_ERR_ACK: assert property (sb_err_o |-> sb_ack_o) else $error("error without ack");
    AST_SB_PULSE: assert property (sb_ack_o |=> !sb_ack_o) else $error("bus ack held");
    AST_BURST: assert property (!$stable(burst_size_o) |-> ack_o && $past(we_i) && $past(cyc_i))
        else $error("burst size moved without write");
    cover property (mem_o.rd);
    cover property (sb_err_o);
    cover property (mem_o.wr);
endmodule // ddr_cal_properties
bind ddr_read_window_cal_and_ecc ddr_cal_properties #(.DLY_W(DLY_W)) u_props (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .sb_req_i(sb_req_i), .sb_i(sb_i),
    .sb_ack_o(sb_ack_o), .sb_err_o(sb_err_o), .mem_o(mem_o), .burst_size_o(burst_size_o));

// >>> verif/ddr_mem_model.sv
// Purpose: Behavioural memory pair answering each read with a two-row burst.
// Assumes: Lanes show a moving pattern outside the burst.
// Notes:   flip_i corrupts read data only when the bench asks.
`timescale 1ns/1ns
module ddr_mem_model #(
    parameter int LAT = 4 // Cycles from read to first beat
) (
    input  wire logic                  clk_i,   // Clock
    input  wire ddr_cal_pkg::mem_req_t mem_i,   // Controller request
    input  wire logic [15:0]           flip_i,  // Bits to corrupt
    output logic [15:0]                rdata_o  // Lane data
);
    import ddr_cal_pkg::*;
    logic [15:0] mem [int];
    logic [3:0]  tick = 4'h0;
    int          cnt = 99;
    int          row = 0;
    function automatic logic [15:0] get(input int r);
        return mem.exists(r) ? mem[r] : 16'h0000;
    endfunction
    always @(posedge clk_i) begin
        tick <= tick + 4'h1;
        if (mem_i.wr && !mem.exists(int'(mem_i.row))) mem[int'(mem_i.row)] = 16'h0000;
        if (mem_i.wr && mem_i.be[0]) mem[int'(mem_i.row)][7:0] = mem_i.wdata[7:0];
        if (mem_i.wr && mem_i.be[1]) mem[int'(mem_i.row)][15:8] = mem_i.wdata[15:8];
        row <= mem_i.rd ? int'(mem_i.row) : row;
        cnt <= mem_i.rd ? 0 : (cnt < 99 ? cnt + 1 : cnt);
        // Never 00 or FF off the burst, so a stale sample cannot pass calibration
        rdata_o <= (cnt >= LAT && cnt < LAT + 8) ? get(row + (cnt - LAT) / 4) ^ flip_i : {2{4'h5, tick}};
    end
endmodule // ddr_mem_model

// >>> verif/ddr_read_window_cal_and_ecc_tb.sv
// Purpose: Self-checking bench for calibration, ECC, map and interrupts.
// Assumes: Expected bytes come from a reference array, not the design.
// Notes:   Random data from a 16-bit shift register.
`timescale 1ns/1ns
`include "ddr_cal_params.svh"
module ddr_read_window_cal_and_ecc_tb;
    import ddr_cal_pkg::*;
    localparam int MAXD = 15;
    logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, init_done_i, sb_req_i, sb_ack_o, sb_err_o, irq_o;
    logic [5:2]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o;
    logic [7:0]  sb_rdata_o;
    logic [15:0] mem_rdata_i, flip;
    logic [1:0]  burst_size_o;
    sb_req_t     sb_i;
    mem_req_t    mem_o;
    logic [7:0]  refm [int];
    logic [15:0] seed = 16'hD581;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    logic [31:0] mc [4] = '{32'h07, 32'h07, 32'h87, 32'hF7};
    logic [31:0] ma [4] = '{32'h10000000, 32'h40000000, 32'h40000000, 32'h40000000};
    logic [15:0] ef [3] = '{16'h0001, 16'h0001, 16'h0003};
    ddr_read_window_cal_and_ecc DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .init_done_i(init_done_i), .sb_req_i(sb_req_i), .sb_i(sb_i), .sb_ack_o(sb_ack_o),
        .sb_err_o(sb_err_o), .sb_rdata_o(sb_rdata_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
        .burst_size_o(burst_size_o), .irq_o(irq_o));
    ddr_mem_model u_mem (.clk_i(clk_i), .mem_i(mem_o), .flip_i(flip), .rdata_o(mem_rdata_i));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask
    task automatic give_verdict;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wb(input logic [5:2] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic sbx(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [7:0] q,
                       output logic e);
        sb_req_i <= 1'b1;
        sb_i <= '{we: w, addr: a, wdata: d};
        @(posedge clk_i);
        sb_req_i <= 1'b0;
        do @(posedge clk_i); while (sb_ack_o !== 1'b1);
        q = sb_rdata_o;
        e = sb_err_o;
        @(posedge clk_i);
    endtask
    function automatic void bump(input logic [7:0] b, input int ph, inout int d, inout int inc);
        if (b !== (ph ? 8'h00 : 8'hFF) && d < MAXD) begin
            d++;
            inc = 1;
        end
    endfunction
    task automatic cal(input int two);
        logic [31:0] q;
        logic [7:0]  b0, b1;
        logic        e;
        int          d0, d1, inc, ph;
        wb(`OFS_CONFIG, 1'b1, two ? 32'h07 : 32'h00, q);
        for (int i = 0; i < 4 + 4 * two; i++) sbx(1'b1, `DDR_BASE + i, i < 1 + two ? 8'hFF : 8'h00, b0, e);
        d0 = 0;
        d1 = 0;
        wb(`OFS_DELAY, 1'b1, 32'h0, q);
        for (ph = 0; ph < 2; ph++) begin
            do begin
                inc = 0;
                sbx(1'b0, `DDR_BASE, 8'h00, b0, e);
                bump(b0, ph, d0, inc);
                if (two) sbx(1'b0, `DDR_BASE + 1, 8'h00, b1, e);
                if (two) bump(b1, ph, d1, inc);
                wb(`OFS_DELAY, 1'b1, 32'(d1 << 8 | d0), q);
            end while (inc);
        end
        chk(32'(d0 < MAXD && d1 < MAXD), 32'h1);
        d0 -= 3;
        d1 -= two * 3;
        wb(`OFS_DELAY, 1'b1, 32'(d1 << 8 | d0), q);
        wb(`OFS_DELAY, 1'b0, 32'h0, q);
        chk(q, 32'(d1 << 8 | d0));
    endtask
    task automatic rw(input int n);
        logic [7:0] b;
        logic       e;
        refm.delete();
        repeat (n) begin
            seed = lfsr(seed);
            refm[int'(seed[7:0])] = seed[15:8];
            sbx(1'b1, `DDR_BASE + seed[7:0], seed[15:8], b, e);
        end
        foreach (refm[k]) begin
            sbx(1'b0, `DDR_BASE + k, 8'h00, b, e);
            chk({24'h0, b}, {24'h0, refm[k]});
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        logic [31:0] q;
        logic [7:0]  b;
        logic        e;
        logic [31:0] dq;
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, sb_req_i, init_done_i} = 5'h00;
        adr_i = 4'h0;
        sel_i = 4'h0;
        dat_i = 32'h0;
        sb_i = '0;
        flip = 16'h0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            wb(4'(i), 1'b0, 32'h0, q);
            chk(q, 32'h0);
        end
        chk(burst_size_o, 32'h0);
        init_done_i <= 1'b1;
        do wb(`OFS_STATUS, 1'b0, 32'h0, q); while (q[0] !== 1'b1);
        cal(0);
        rw(6);
        cal(1);
        chk(burst_size_o, 32'h3);
        rw(6);
        for (int i = 0; i < 4; i++) begin
            wb(`OFS_CONFIG, 1'b1, mc[i], q);
            sbx(1'b1, ma[i], 8'h3C, b, e);
            chk(e, 32'(i != 2));
            if (i == 2) sbx(1'b0, ma[i], 8'h00, b, e);
            if (i == 2) chk(b, 32'h3C);
        end
        wb(`OFS_STATUS, 1'b0, 32'h0, q);
        chk(q, 32'h3);
        wb(`OFS_IRQ_MASK, 1'b1, 32'h0, q);
        chk(irq_o, 32'h0);
        wb(`OFS_IRQ_MASK, 1'b1, 32'h8, q);
        chk(irq_o, 32'h1);
        wb(`OFS_IRQ_STAT, 1'b1, 32'h8, q);
        chk(irq_o, 32'h0);
        wb(`OFS_DELAY, 1'b0, 32'h0, dq);
        wb(`OFS_DELAY, 1'b1, dq | 32'hF, q);
        wb(`OFS_STATUS, 1'b0, 32'h0, q);
        chk(q, 32'h7);
        wb(`OFS_DELAY, 1'b1, dq, q);
        wb(`OFS_IRQ_STAT, 1'b0, 32'h0, q);
        chk(q, 32'h4);
        wb(`OFS_IRQ_STAT, 1'b1, 32'hF, q);
        wb(`OFS_CONFIG, 1'b1, 32'h31, q);
        chk(burst_size_o, 32'h0);
        rw(4);
        sbx(1'b1, `DDR_BASE + 16, 8'hA5, b, e);
        for (int i = 0; i < 3; i++) begin
            wb(`OFS_CONFIG, 1'b1, i == 1 ? 32'h71 : 32'h31, q);
            flip <= ef[i];
            sbx(1'b0, `DDR_BASE + 16, 8'h00, b, e);
            flip <= 16'h0;
            chk(e, 32'(i > 0));
            if (i < 2) chk(b, 32'hA5);
            wb(`OFS_IRQ_STAT, 1'b0, 32'h0, q);
            chk(q, i < 2 ? 32'h1 : 32'h2);
            wb(`OFS_IRQ_STAT, 1'b1, 32'hF, q);
        end
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(`OFS_CONFIG, 1'b0, 32'h0, q);
        chk(q | burst_size_o | irq_o, 32'h0);
        wb(`OFS_DELAY, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        give_verdict();
    end
endmodule // ddr_read_window_cal_and_ecc_tb
